// [hdl/mms_pkg.sv]
package mms_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Monitor opcodes with fixed values
    localparam logic [7:0]  OP_SP_READ    = 8'h0C;
    localparam logic [7:0]  OP_IDX_READ   = 8'h1A;
    localparam logic [7:0]  OP_WRITE      = 8'h49;

    // Operand byte counts per command
    localparam logic [1:0]  WRITE_OPNDS   = 2'h3;
    localparam logic [1:0]  IDX_WR_OPNDS  = 2'h1;
    localparam logic [1:0]  NO_OPNDS      = 2'h0;

    // Bytes returned by read style commands
    localparam logic [1:0]  IDX_RD_BYTES  = 2'h2;
    localparam logic [1:0]  SP_RD_BYTES   = 2'h2;
    localparam logic [1:0]  ECHO_BYTES    = 2'h1;

    ////////////////////////////////////////////////////////////////////////
    // Security key: eight bytes held at the top of the map
    localparam int          SEC_LEN       = 8;
    localparam logic [15:0] SEC_FIRST     = 16'hFFF6;
    localparam logic [15:0] SEC_LAST      = 16'hFFFD;
    localparam logic [7:0]  BLANK_BYTE    = 8'hFF;

    // Status byte in RAM telling the host whether flash is open
    localparam logic [15:0] STAT_ADDR     = 16'h0040;
    localparam int          STAT_BIT      = 6;

    // Stack layout at monitor entry
    localparam logic [15:0] SP_INC        = 16'h0001;
    localparam logic [15:0] PC_HI_OFS     = 16'h0005;
    localparam logic [15:0] PC_LO_OFS     = 16'h0006;
    localparam logic [15:0] ADDR_STEP     = 16'h0001;

    ////////////////////////////////////////////////////////////////////////
    // Instructions forced into the core
    typedef enum logic [1:0] {
        CPU_SOFT_INT  = 2'h0,
        CPU_PUSH_IDXH = 2'h1,
        CPU_POP_IDXH  = 2'h2,
        CPU_RET_INT   = 2'h3
    } mms_cpu_op_type;

    // Monitor states, one-hot
    typedef enum logic [10:0] {
        ST_ENTRY = 11'h001,
        ST_SEC   = 11'h002,
        ST_STAT  = 11'h004,
        ST_IDLE  = 11'h008,
        ST_OPND  = 11'h010,
        ST_TX    = 11'h020,
        ST_RD    = 11'h040,
        ST_WR    = 11'h080,
        ST_RUN   = 11'h100,
        ST_USER  = 11'h200,
        ST_SPARE = 11'h400
    } mms_st_type;

endpackage

// [hdl/mms_sec_check.sv]
module mms_sec_check
    import mms_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        restart,
    // Received security bytes
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    // Reserved key bytes, lowest address in bits 7:0
    input  wire logic [63:0] key_bytes,
    input  wire logic        erased,
    // Result
    output logic             done,
    output logic             match
);
    import mms_pkg::*;

    typedef struct packed {
        logic [2:0] idx;
        logic       ok;
        logic       done;
        logic       match;
    } mms_sec_type;

    localparam mms_sec_type SEC_RST = '{idx: 3'h0, ok: 1'b1,
                                        done: 1'b0, match: 1'b0};

    mms_sec_type r_reg;
    mms_sec_type r_next;
    logic [7:0]  key_arr [SEC_LEN];

    ////////////////////////////////////////////////////////////////////////
    // Key bytes, blank after a mass erase
    genvar gi;
    generate
        for (gi = 0; gi < SEC_LEN; gi++)
        begin : g_key
            assign key_arr[gi] = erased ? BLANK_BYTE
                                        : key_bytes[8*gi +: 8];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Byte by byte compare, result only after all eight
    always_comb
    begin
        r_next = r_reg;
        if (restart)
        begin
            r_next = SEC_RST;
        end
        else if (byte_valid && !r_reg.done)
        begin
            r_next.ok  = r_reg.ok && (byte_data == key_arr[r_reg.idx]);
            r_next.idx = r_reg.idx + 3'h1;
            if (r_reg.idx == 3'(SEC_LEN - 1))
            begin
                r_next.done  = 1'b1;
                r_next.match = r_next.ok;
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            r_reg <= SEC_RST;
        else
            r_reg <= r_next;
    end

    assign done  = r_reg.done;
    assign match = r_reg.match;

endmodule // mms_sec_check

// [hdl/mms_monitor.sv]
module mms_monitor
    import mms_pkg::*;
#(
    parameter logic [15:0] FLASH_BASE   = 16'h8000,
    parameter logic [7:0]  INVALID_BYTE = 8'h00,
    parameter logic [7:0]  OP_IDX_WRITE = 8'h19,
    parameter logic [7:0]  OP_RUN       = 8'h28
)
(
    // Clock, power-on reset, other resets
    input  wire logic                    clock,
    input  wire logic                    nrst,
    input  wire logic                    sys_rst,
    // Bytes from the monitor serial pin
    input  wire logic                    rx_valid,
    input  wire logic [7:0]              rx_data,
    // Bytes to the monitor serial pin
    output logic                         tx_valid,
    output logic [7:0]                   tx_data,
    output logic                         tx_break,
    input  wire logic                    tx_ready,
    // Memory access
    output logic                         mem_req,
    output logic                         mem_we,
    output logic [15:0]                  mem_addr,
    output logic [7:0]                   mem_wdata,
    input  wire logic                    mem_ack,
    input  wire logic [7:0]              mem_rdata,
    // Core control
    output logic                         cpu_op_valid,
    output mms_pkg::mms_cpu_op_type      cpu_op,
    input  wire logic                    cpu_op_done,
    input  wire logic [15:0]             stack_ptr,
    input  wire logic                    fetch_valid,
    input  wire logic [15:0]             fetch_addr,
    output logic                         illegal_rst,
    // Flash key and erase
    input  wire logic [63:0]             key_bytes,
    input  wire logic                    erase_done,
    output logic                         flash_open
);
    import mms_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State record
    typedef struct packed {
        mms_st_type     state;
        mms_st_type     after;
        logic           tx_valid;
        logic [7:0]     tx_data;
        logic           tx_break;
        logic [1:0]     sendn;
        logic [15:0]    sendbuf;
        logic           mem_req;
        logic           mem_we;
        logic [15:0]    mem_addr;
        logic [7:0]     mem_wdata;
        logic [1:0]     rdn;
        logic           cpu_op_valid;
        mms_cpu_op_type cpu_op;
        logic           illegal_rst;
        logic [7:0]     cmd;
        logic [1:0]     cnt;
        logic [15:0]    addr;
        logic [7:0]     wbuf;
        logic           unlocked;
        logic           erased;
    } mms_regs_type;

    localparam mms_regs_type REGS_RST = '{
        state: ST_ENTRY, after: ST_IDLE, tx_valid: 1'b0, tx_data: 8'h00,
        tx_break: 1'b0, sendn: 2'h0, sendbuf: 16'h0000, mem_req: 1'b0,
        mem_we: 1'b0, mem_addr: 16'h0000, mem_wdata: 8'h00, rdn: 2'h0,
        cpu_op_valid: 1'b1, cpu_op: CPU_SOFT_INT, illegal_rst: 1'b0,
        cmd: 8'h00, cnt: 2'h0, addr: 16'h0000, wbuf: 8'h00,
        unlocked: 1'b0, erased: 1'b0};

    mms_regs_type r_reg;
    mms_regs_type r_next;
    logic         sec_valid;
    logic         sec_done;
    logic         sec_match;
    logic [7:0]   rd_byte;

    ////////////////////////////////////////////////////////////////////////
    // Security byte compare
    assign sec_valid = rx_valid && !r_reg.unlocked
                       && (r_reg.state == ST_ENTRY || r_reg.state == ST_SEC);

    mms_sec_check u_sec (
        .clock      (clock),
        .nrst       (nrst),
        .restart    (sys_rst),
        .byte_valid (sec_valid),
        .byte_data  (rx_data),
        .key_bytes  (key_bytes),
        .erased     (r_reg.erased),
        .done       (sec_done),
        .match      (sec_match)
    );

    // Read data from FLASH_BASE up masked while flash is locked
    assign rd_byte = (!r_reg.unlocked && r_reg.mem_addr >= FLASH_BASE)
                     ? INVALID_BYTE : mem_rdata;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        r_next = r_reg;
        r_next.illegal_rst = fetch_valid && !r_reg.unlocked
                             && fetch_addr >= FLASH_BASE;
        // Erase allowed in any lock state; key then reads blank
        if (erase_done)
            r_next.erased = 1'b1;
        case (r_reg.state)
            ST_ENTRY:
            begin
                if (cpu_op_done)
                begin
                    if (r_reg.cpu_op == CPU_SOFT_INT)
                        r_next.cpu_op = CPU_PUSH_IDXH;
                    else
                    begin
                        r_next.cpu_op_valid = 1'b0;
                        r_next.state = r_reg.unlocked ? ST_IDLE
                                                      : ST_SEC;
                    end
                end
            end
            ST_SEC:
            begin
                if (sec_done)
                begin
                    r_next.unlocked = sec_match;
                    r_next.tx_valid = 1'b1;
                    r_next.tx_break = 1'b1;
                    r_next.tx_data  = 8'h00;
                    r_next.sendn    = ECHO_BYTES;
                    r_next.state    = ST_TX;
                    r_next.after    = ST_STAT;
                end
            end
            ST_STAT:
            begin
                r_next.mem_req   = 1'b1;
                r_next.mem_we    = 1'b1;
                r_next.mem_addr  = STAT_ADDR;
                r_next.mem_wdata = 8'h00;
                r_next.mem_wdata[STAT_BIT] = r_reg.unlocked;
                if (r_reg.mem_req && mem_ack)
                begin
                    r_next.addr    = r_reg.mem_addr;
                    r_next.mem_req = 1'b0;
                    r_next.mem_we  = 1'b0;
                    r_next.state   = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                if (rx_valid)
                begin
                    r_next.cmd      = rx_data;
                    r_next.tx_valid = 1'b1;
                    r_next.tx_data  = rx_data;
                    r_next.sendn    = ECHO_BYTES;
                    r_next.state    = ST_TX;
                    r_next.after    = ST_OPND;
                    if (rx_data == OP_WRITE)
                        r_next.cnt = WRITE_OPNDS;
                    else if (rx_data == OP_IDX_WRITE)
                        r_next.cnt = IDX_WR_OPNDS;
                    else
                        r_next.cnt = NO_OPNDS;
                end
            end
            ST_OPND:
            begin
                if (r_reg.cnt != NO_OPNDS)
                begin
                    if (rx_valid)
                    begin
                        if (r_reg.cnt == 2'h1)
                            r_next.wbuf = rx_data;
                        else
                            r_next.addr = {r_reg.addr[7:0], rx_data};
                        r_next.cnt      = r_reg.cnt - 2'h1;
                        r_next.tx_valid = 1'b1;
                        r_next.tx_data  = rx_data;
                        r_next.sendn    = ECHO_BYTES;
                        r_next.state    = ST_TX;
                        r_next.after    = ST_OPND;
                    end
                end
                else if (r_reg.cmd == OP_IDX_READ)
                begin
                    r_next.rdn      = IDX_RD_BYTES;
                    r_next.mem_req  = 1'b1;
                    r_next.mem_addr = r_reg.addr + ADDR_STEP;
                    r_next.state    = ST_RD;
                end
                else if (r_reg.cmd == OP_SP_READ)
                begin
                    r_next.sendbuf  = stack_ptr + SP_INC;
                    r_next.tx_valid = 1'b1;
                    r_next.tx_data  = r_next.sendbuf[15:8];
                    r_next.sendn    = SP_RD_BYTES;
                    r_next.state    = ST_TX;
                    r_next.after    = ST_IDLE;
                end
                else if (r_reg.cmd == OP_WRITE || r_reg.cmd == OP_IDX_WRITE)
                begin
                    // Host may patch stacked PC at SP+5/SP+6 this way
                    r_next.mem_req   = 1'b1;
                    r_next.mem_we    = 1'b1;
                    r_next.mem_wdata = r_reg.wbuf;
                    r_next.mem_addr  = (r_reg.cmd == OP_IDX_WRITE)
                                       ? r_reg.addr + ADDR_STEP
                                       : r_reg.addr;
                    r_next.state     = ST_WR;
                end
                else if (r_reg.cmd == OP_RUN)
                begin
                    r_next.cpu_op_valid = 1'b1;
                    r_next.cpu_op       = CPU_POP_IDXH;
                    r_next.state        = ST_RUN;
                end
                else
                    r_next.state = ST_IDLE;
            end
            ST_TX:
            begin
                if (tx_ready)
                begin
                    if (r_reg.sendn > ECHO_BYTES)
                    begin
                        r_next.sendn   = r_reg.sendn - 2'h1;
                        r_next.tx_data = r_reg.sendbuf[7:0];
                    end
                    else
                    begin
                        r_next.sendn    = 2'h0;
                        r_next.tx_valid = 1'b0;
                        r_next.tx_break = 1'b0;
                        r_next.state    = r_reg.after;
                    end
                end
            end
            ST_RD:
            begin
                if (mem_ack)
                begin
                    r_next.addr = r_reg.mem_addr;
                    if (r_reg.rdn == IDX_RD_BYTES)
                    begin
                        r_next.sendbuf[15:8] = rd_byte;
                        r_next.rdn      = 2'h1;
                        r_next.mem_addr = r_reg.mem_addr + ADDR_STEP;
                    end
                    else
                    begin
                        r_next.sendbuf[7:0] = rd_byte;
                        r_next.rdn      = 2'h0;
                        r_next.mem_req  = 1'b0;
                        r_next.tx_valid = 1'b1;
                        r_next.tx_data  = r_reg.sendbuf[15:8];
                        r_next.sendn    = IDX_RD_BYTES;
                        r_next.state    = ST_TX;
                        r_next.after    = ST_IDLE;
                    end
                end
            end
            ST_WR:
            begin
                if (mem_ack)
                begin
                    r_next.addr    = r_reg.mem_addr;
                    r_next.mem_req = 1'b0;
                    r_next.mem_we  = 1'b0;
                    r_next.state   = ST_IDLE;
                end
            end
            ST_RUN:
            begin
                if (cpu_op_done)
                begin
                    if (r_reg.cpu_op == CPU_POP_IDXH)
                        r_next.cpu_op = CPU_RET_INT;
                    else
                    begin
                        r_next.cpu_op_valid = 1'b0;
                        r_next.state        = ST_USER;
                    end
                end
            end
            ST_USER:
                r_next.state = ST_USER;
            default:
                r_next.state = ST_IDLE;
        endcase
        // Other resets keep the open state and erase marker
        if (sys_rst)
        begin
            r_next          = REGS_RST;
            r_next.unlocked = r_reg.unlocked;
            r_next.erased   = r_reg.erased;
        end
    end

    // State register; only power-on clears the open state
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            r_reg <= REGS_RST;
        else
            r_reg <= r_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign tx_valid     = r_reg.tx_valid;
    assign tx_data      = r_reg.tx_data;
    assign tx_break     = r_reg.tx_break;
    assign mem_req      = r_reg.mem_req;
    assign mem_we       = r_reg.mem_we;
    assign mem_addr     = r_reg.mem_addr;
    assign mem_wdata    = r_reg.mem_wdata;
    assign cpu_op_valid = r_reg.cpu_op_valid;
    assign cpu_op       = r_reg.cpu_op;
    assign illegal_rst  = r_reg.illegal_rst;
    assign flash_open   = r_reg.unlocked;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_idx_step;
        (r_reg.state == ST_RD && mem_ack && r_reg.rdn == IDX_RD_BYTES
         && !sys_rst) |=> mem_addr == $past(mem_addr) + ADDR_STEP;
    endproperty
    a_idx_step: assert property (p_idx_step)
        else $error("indexed read did not step address");

    property p_idx_start;
        (r_reg.state == ST_OPND && r_reg.cnt == NO_OPNDS
         && r_reg.cmd == OP_IDX_READ && !sys_rst)
        |=> mem_req && !mem_we && mem_addr == $past(r_reg.addr) + ADDR_STEP;
    endproperty
    a_idx_start: assert property (p_idx_start)
        else $error("indexed read started at wrong address");

    property p_sp_read;
        (r_reg.state == ST_OPND && r_reg.cnt == NO_OPNDS
         && r_reg.cmd == OP_SP_READ && !sys_rst)
        |=> tx_valid && tx_data == 8'($past(stack_ptr) + SP_INC >> 8);
    endproperty
    a_sp_read: assert property (p_sp_read)
        else $error("stack pointer high byte wrong");

    property p_entry;
        (r_reg.state == ST_ENTRY && cpu_op == CPU_SOFT_INT && cpu_op_done
         && !sys_rst) |=> cpu_op_valid && cpu_op == CPU_PUSH_IDXH;
    endproperty
    a_entry: assert property (p_entry)
        else $error("push index high did not follow interrupt");

    property p_run;
        (r_reg.state == ST_RUN && cpu_op == CPU_POP_IDXH && cpu_op_done
         && !sys_rst) |=> cpu_op_valid && cpu_op == CPU_RET_INT;
    endproperty
    a_run: assert property (p_run)
        else $error("return did not follow pop index high");

    property p_keep_open;
        flash_open |=> flash_open;
    endproperty
    a_keep_open: assert property (p_keep_open)
        else $error("open state lost without power-on reset");

    property p_locked_read;
        (r_reg.state == ST_RD && mem_ack && r_reg.rdn == 2'h1
         && !flash_open && mem_addr >= FLASH_BASE && !sys_rst)
        |=> r_reg.sendbuf[7:0] == INVALID_BYTE;
    endproperty
    a_locked_read: assert property (p_locked_read)
        else $error("locked flash read leaked data");

    property p_illegal;
        (fetch_valid && !flash_open && fetch_addr >= FLASH_BASE)
        |=> illegal_rst;
    endproperty
    a_illegal: assert property (p_illegal)
        else $error("locked fetch gave no illegal address reset");

    property p_break;
        $rose(tx_break) |-> sec_done && $past(r_reg.state == ST_SEC);
    endproperty
    a_break: assert property (p_break)
        else $error("break sent before eight security bytes");

    property p_echo;
        (r_reg.state == ST_IDLE && rx_valid && !sys_rst)
        |=> tx_valid && !tx_break && tx_data == $past(rx_data);
    endproperty
    a_echo: assert property (p_echo)
        else $error("command byte not echoed");

    property p_status;
        (r_reg.state == ST_STAT && mem_req)
        |-> mem_we && mem_addr == STAT_ADDR
            && mem_wdata[STAT_BIT] == flash_open;
    endproperty
    a_status: assert property (p_status)
        else $error("status byte does not show lock state");

    c_open:  cover property ($rose(flash_open));
    c_break: cover property ($rose(tx_break));
    c_idx_rd: cover property (r_reg.state == ST_RD ##[1:20] tx_valid);
    c_user:  cover property (r_reg.state == ST_USER);

endmodule // mms_monitor

// [bench/mms_host_model.sv]
module mms_host_model
(
    // Clock, reset, pace
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        slow,
    // Serializer, memory and core answers
    output logic             tx_ready,
    input  wire logic        mem_req,
    input  wire logic [15:0] mem_addr,
    output logic             mem_ack,
    output logic [7:0]       mem_rdata,
    input  wire logic        cpu_op_valid,
    output logic             cpu_op_done
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] cnt;
    logic       pend;
    assign pend = mem_req || cpu_op_valid;
    // Data inverted outside the acknowledge cycle
    assign mem_rdata = mem_addr[7:0] ^ mem_addr[15:8]
                     ^ (mem_ack ? 8'h5A : 8'hA5);
    // Memory and core answer at once, or after three idle cycles when slow; tx_ready toggles when slow
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt         <= 2'h0;
            mem_ack     <= 1'b0;
            cpu_op_done <= 1'b0;
            tx_ready    <= 1'b0;
        end
        else
        begin
            tx_ready <= !slow || !tx_ready;
            if (pend && !mem_ack && !cpu_op_done
                && cnt == (slow ? 2'h3 : 2'h0))
            begin
                cnt         <= 2'h0;
                mem_ack     <= mem_req;
                cpu_op_done <= cpu_op_valid;
            end
            else
            begin
                mem_ack     <= 1'b0;
                cpu_op_done <= 1'b0;
                cnt <= (pend && !mem_ack && !cpu_op_done) ? cnt + 2'h1 : 2'h0;
            end
        end
    end
endmodule // mms_host_model

// [bench/testbench.sv]
module testbench;
    import mms_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [63:0] KEY = 64'h8877_6655_4433_2211;
    localparam logic [15:0] SP  = 16'h01F0;
    logic clock = 0, nrst = 0, sys_rst = 0, rx_valid = 0, slow = 0;
    logic [7:0] rx_data = 8'h00, tx_data, mem_wdata, mem_rdata;
    logic tx_valid, tx_break, tx_ready, mem_req, mem_we, mem_ack;
    logic cpu_op_valid, cpu_op_done, illegal_rst, flash_open;
    logic [15:0] mem_addr;
    logic fetch_valid = 0, erase_done = 0;
    logic [15:0] fetch_addr = 16'h8000;
    mms_cpu_op_type cpu_op;
    logic [8:0] txq[$];
    logic [1:0] opq[$];
    logic [23:0] wq[$];
    int error_cnt = 0, samples_checked = 0;
    always #10 clock = ~clock;
    mms_monitor #(.OP_RUN(8'h28)) dut_u (.clock, .nrst, .sys_rst,
        .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_break, .tx_ready,
        .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
        .cpu_op_valid, .cpu_op, .cpu_op_done, .stack_ptr(SP),
        .fetch_valid, .fetch_addr, .illegal_rst,
        .key_bytes(KEY), .erase_done, .flash_open);
    mms_host_model host_u (.clock, .nrst, .slow, .tx_ready, .mem_req,
        .mem_addr, .mem_ack, .mem_rdata, .cpu_op_valid, .cpu_op_done);
    // Log accepted bytes, core ops and memory writes
    always @(posedge clock)
    begin
        if (tx_valid && tx_ready) txq.push_back({tx_break, tx_data});
        if (cpu_op_valid && cpu_op_done) opq.push_back(cpu_op);
        if (mem_req && mem_ack && mem_we) wq.push_back({mem_addr, mem_wdata});
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rd(logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    task automatic check(string name, logic [23:0] seen, logic [23:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic expect_tx(string name, logic [8:0] exp);
        for (int i = 0; i < 100 && txq.size() == 0; i++) tick(1);
        check(name, txq.size() ? txq.pop_front() : 'x, exp);
    endtask
    task automatic send_echo(logic [7:0] b);
        rx_valid = 1;
        rx_data = b;
        tick(1);
        rx_valid = 0;
        expect_tx("echo", {1'b0, b});
    endtask
    task automatic ops(string name, logic [1:0] a, logic [1:0] b);
        for (int i = 0; i < 100 && opq.size() < 2; i++) tick(1);
        check(name, opq.size() ? opq.pop_front() : 'x, a);
        check(name, opq.size() ? opq.pop_front() : 'x, b);
    endtask
    task automatic power_on(int n, logic s);
        nrst = 0;
        slow = s;
        tick(n);
        nrst = 1;
        ops("entry", CPU_SOFT_INT, CPU_PUSH_IDXH);
    endtask
    task automatic t_secure(logic [63:0] k, logic ok);
        for (int i = 0; i < 8; i++)
        begin
            rx_valid = 1;
            rx_data = k[8*i +: 8];
            tick(1);
            rx_valid = 0;
            tick(3);
            if (i == 6) check("early", 24'(txq.size()), 0);
        end
        expect_tx("break", 9'h100);
        for (int i = 0; i < 100 && wq.size() == 0; i++) tick(1);
        check("stat", wq.size() ? wq.pop_front() : 'x, {STAT_ADDR, 1'b0, ok, 6'h00});
        check("open", flash_open, ok);
    endtask
    task automatic t_read(logic [7:0] op, logic [15:0] v);
        send_echo(op);
        expect_tx("hi", {1'b0, v[15:8]});
        expect_tx("lo", {1'b0, v[7:0]});
        tick(3);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial
    begin
        #200000;
        error_cnt++;
        summarize();
    end
    // Main sequence
    initial
    begin
        power_on(20, 0);
        t_secure(KEY, 1);
        t_read(OP_SP_READ, SP + SP_INC);
        t_read(OP_IDX_READ, {rd(16'h0041), rd(16'h0042)});
        t_read(OP_IDX_READ, {rd(16'h0043), rd(16'h0044)});
        sys_rst = 1;
        tick(1);
        sys_rst = 0;
        ops("warm", CPU_SOFT_INT, CPU_PUSH_IDXH);
        tick(40);
        check("no key", 24'(txq.size()), 0);
        check("kept", flash_open, 1'b1);
        send_echo(8'h28);
        ops("run", CPU_POP_IDXH, CPU_RET_INT);
        power_on(3, 1);
        t_secure(KEY ^ 64'h1, 0);
        send_echo(OP_WRITE);
        send_echo(8'h80);
        send_echo(8'h00);
        send_echo(8'h33);
        tick(20);
        check("wr", wq.size() ? wq.pop_front() : 'x, {16'h8000, 8'h33});
        t_read(OP_IDX_READ, 16'h0000);
        fetch_valid = 1;
        tick(1);
        fetch_valid = 0;
        check("illegal", illegal_rst, 1'b1);
        erase_done = 1;
        tick(1);
        erase_done = 0;
        sys_rst = 1;
        tick(1);
        sys_rst = 0;
        ops("warm2", CPU_SOFT_INT, CPU_PUSH_IDXH);
        t_secure({8{8'hFF}}, 1);
        power_on(3, 0);
        t_secure(KEY, 1);
        summarize();
    end
endmodule // testbench
